// file: common/clk_src_sel_defines.vh
// Offsets, field positions, reset values and timing counts for the CPU clock source selector
`ifndef CLK_SRC_SEL_DEFINES_VH
`define CLK_SRC_SEL_DEFINES_VH
// Register byte offsets (APB, one word each)
`define OFS_PROC_CLK_CTRL 12'h000
`define OFS_MAIN_OSC_CTRL 12'h004
`define OFS_RING_OSC_MODE 12'h008
`define OFS_MAIN_CLK_MODE 12'h00C
`define OFS_OSC_STAB_STAT 12'h010
`define OFS_OSC_STAB_SEL 12'h014
// Processor clock control fields
`define BIT_PROC_XTAL_STOP 7
`define BIT_SUBSYS_STATUS 5
`define BIT_SUBSYS_SELECT 4
// Main osc control / ring osc mode fields
`define BIT_MAIN_OSC_STOP 7
`define BIT_RING_OSC_STOP 0
// Main clock mode fields
`define BIT_MAIN_SRC_STATUS 1
`define BIT_MAIN_SRC_SELECT 0
// Oscillation stabilisation fields
`define BIT_STAB_DONE 0
`define STAB_SEL_W 3
// Reset values
`define RST_SEL_REG 3'h0
// Synchroniser stages for the clock edge detectors
`define SYNC_STAGES 2
`endif

// file: rtl/clk_src_sel.v
// CPU clock source selector with APB register access and oscillator stop control
// Overview of operation
// - Stabilisation time applies only on crystal STOP release
// - Crystal keeps running while it clocks CPU
// - Ring mode: only main stop halts crystal
// - Subsystem entered and left only via crystal
// - Subsystem mode: only processor stop halts crystal
// - Status flags report the actually running source
// - Ring stop honoured only when mask permits
// - Subsystem mode: independent crystal and ring stops
// - Source status changes only after switch completes
// - Main source select bit zero picks crystal
// - Subsystem status bit five, select bit four
`timescale 1ns/1ps
`include "clk_src_sel_defines.vh"
module clk_src_sel #(
  parameter STAB_W = 16
) (
  // System
  input wire clk_sys,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Oscillator clocks, asynchronous to clk_sys
  input wire ringClk,
  input wire xtalClk,
  input wire subClk,
  // Mask option strap and stabilisation events
  input wire ringStopAllowed,
  input wire xtalStable,
  input wire stopReleaseIrq,
  // Oscillator enables and selected CPU clock phase
  output reg xtalEnable,
  output reg ringEnable,
  output reg cpuClkOut,
  output reg [2:0] activeSrc,
  output reg [2:0] stabTimeApplied
);
  localparam SRC_RING = 3'h1;
  localparam SRC_XTAL = 3'h2;
  localparam SRC_SUB = 3'h4;
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT_OLD = 2'h1;
  localparam ST_WAIT_NEW = 2'h2;

  // Setting flags written by software
  reg procXtalStop_q, subsysSelect_q, mainSourceSelect_q, mainOscStop_q, ringOscStop_q;
  reg [`STAB_SEL_W-1:0] stabSel_q;
  // Switching state
  reg [1:0] state_q;
  reg [2:0] target_q;
  reg [STAB_W-1:0] stabCnt_q;
  reg strapCaught_q, ringStopAllowed_q;

  // Two-flop synchronisers for async oscillator clocks and pins
  reg [`SYNC_STAGES-1:0] ringSync_q, xtalSync_q, subSync_q, stabSync_q, irqSync_q, strapSync_q;
  reg ringPrev_q, xtalPrev_q, subPrev_q;
  always @(posedge clk_sys) begin
    ringSync_q <= {ringSync_q[0], ringClk};
    xtalSync_q <= {xtalSync_q[0], xtalClk};
    subSync_q <= {subSync_q[0], subClk};
    stabSync_q <= {stabSync_q[0], xtalStable};
    irqSync_q <= {irqSync_q[0], stopReleaseIrq};
    strapSync_q <= {strapSync_q[0], ringStopAllowed};
    ringPrev_q <= ringSync_q[1];
    xtalPrev_q <= xtalSync_q[1];
    subPrev_q <= subSync_q[1];
  end

  // Falling edge of a source marks the end of its current cycle
  function srcFall;
    input [2:0] src;
    begin
      srcFall = (src[0] & ringPrev_q & ~ringSync_q[1]) |
                (src[1] & xtalPrev_q & ~xtalSync_q[1]) |
                (src[2] & subPrev_q & ~subSync_q[1]);
    end
  endfunction

  function srcLevel;
    input [2:0] src;
    begin
      srcLevel = (src[0] & ringSync_q[1]) | (src[1] & xtalSync_q[1]) | (src[2] & subSync_q[1]);
    end
  endfunction

  // Write lands only at the edge where the master sees pready high
  wire wrEn = psel & penable & pwrite & pready;
  wire mapped = (paddr == `OFS_PROC_CLK_CTRL) | (paddr == `OFS_MAIN_OSC_CTRL) |
                (paddr == `OFS_RING_OSC_MODE) | (paddr == `OFS_MAIN_CLK_MODE) |
                (paddr == `OFS_OSC_STAB_STAT) | (paddr == `OFS_OSC_STAB_SEL);
  wire onSub = (activeSrc == SRC_SUB);
  wire onXtal = (activeSrc == SRC_XTAL);
  wire onRing = (activeSrc == SRC_RING);

  // Requested source from the setting flags
  reg [2:0] wantSrc;
  always @* begin
    if (subsysSelect_q) begin
      wantSrc = SRC_SUB;
    end else if (mainSourceSelect_q) begin
      wantSrc = SRC_XTAL;
    end else begin
      wantSrc = SRC_RING;
    end
  end

  // Legal transitions only: ring and subsystem never swap directly
  wire legalMove = !((onRing && wantSrc == SRC_SUB) || (onSub && wantSrc == SRC_RING));

  // Software settings; strap caught once after reset release
  always @(posedge clk_sys) begin
    if (!nrst) begin
      procXtalStop_q <= 1'b0;
      subsysSelect_q <= 1'b0;
      mainSourceSelect_q <= 1'b0;
      mainOscStop_q <= 1'b0;
      ringOscStop_q <= 1'b0;
      stabSel_q <= `RST_SEL_REG;
      strapCaught_q <= 1'b0;
      ringStopAllowed_q <= 1'b0;
    end else begin
      if (!strapCaught_q) begin
        strapCaught_q <= 1'b1;
        ringStopAllowed_q <= strapSync_q[1];
      end
      if (wrEn && paddr == `OFS_PROC_CLK_CTRL) begin
        procXtalStop_q <= pwdata[`BIT_PROC_XTAL_STOP];
        // Subsystem select from ring mode is refused
        if (!(onRing && pwdata[`BIT_SUBSYS_SELECT])) begin
          subsysSelect_q <= pwdata[`BIT_SUBSYS_SELECT];
        end
      end
      if (wrEn && paddr == `OFS_MAIN_OSC_CTRL) begin
        mainOscStop_q <= pwdata[`BIT_MAIN_OSC_STOP];
      end
      if (wrEn && paddr == `OFS_RING_OSC_MODE) begin
        ringOscStop_q <= pwdata[`BIT_RING_OSC_STOP];
      end
      // Clearing source select in subsystem mode is ignored
      if (wrEn && paddr == `OFS_MAIN_CLK_MODE && !(onSub || subsysSelect_q)) begin
        mainSourceSelect_q <= pwdata[`BIT_MAIN_SRC_SELECT];
      end
      if (wrEn && paddr == `OFS_OSC_STAB_SEL) begin
        stabSel_q <= pwdata[`STAB_SEL_W-1:0];
      end
    end
  end

  // Switch sequencer: finish old cycle low, then wait new clock low
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= ST_RUN;
      target_q <= SRC_RING;
      activeSrc <= SRC_RING;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (wantSrc != activeSrc && legalMove) begin
            target_q <= wantSrc;
            state_q <= ST_WAIT_OLD;
          end
        end
        ST_WAIT_OLD: begin
          if (srcFall(activeSrc)) begin
            state_q <= ST_WAIT_NEW;
          end
        end
        ST_WAIT_NEW: begin
          // Gate stays low until new clock is low, so no runt pulse
          if (!srcLevel(target_q)) begin
            activeSrc <= target_q;
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Gated CPU clock phase; held low between sources
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cpuClkOut <= 1'b0;
    end else begin
      cpuClkOut <= (state_q == ST_RUN) ? srcLevel(activeSrc) : 1'b0;
    end
  end

  // Oscillator enables by active mode
  always @(posedge clk_sys) begin
    if (!nrst) begin
      xtalEnable <= 1'b0;
      ringEnable <= 1'b1;
    end else begin
      if (onXtal || state_q != ST_RUN) begin
        xtalEnable <= 1'b1;
      end else if (onRing) begin
        xtalEnable <= ~mainOscStop_q;
      end else begin
        xtalEnable <= ~procXtalStop_q;
      end
      // Ring may stop only when it is not the CPU clock
      ringEnable <= ~(ringStopAllowed_q && ringOscStop_q && !onRing && state_q == ST_RUN);
    end
  end

  // Stabilisation wait: count while crystal is stable; STOP release interrupt on crystal restarts count and latches time
  always @(posedge clk_sys) begin
    if (!nrst) begin
      stabCnt_q <= {STAB_W{1'b0}};
      stabTimeApplied <= `RST_SEL_REG;
    end else if (irqSync_q[1] && onXtal) begin
      stabTimeApplied <= stabSel_q;
      stabCnt_q <= {STAB_W{1'b0}};
    end else if (stabSync_q[1] && stabCnt_q != {STAB_W{1'b1}}) begin
      stabCnt_q <= stabCnt_q + 1'b1;
    end
  end

  // APB read and answer, one wait-free access phase
  always @(posedge clk_sys) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable | (psel & penable & ~pready);
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `OFS_PROC_CLK_CTRL: begin
            prdata[`BIT_PROC_XTAL_STOP] <= procXtalStop_q;
            prdata[`BIT_SUBSYS_STATUS] <= onSub;
            prdata[`BIT_SUBSYS_SELECT] <= subsysSelect_q;
          end
          `OFS_MAIN_OSC_CTRL: prdata[`BIT_MAIN_OSC_STOP] <= mainOscStop_q;
          `OFS_RING_OSC_MODE: prdata[`BIT_RING_OSC_STOP] <= ringOscStop_q;
          `OFS_MAIN_CLK_MODE: begin
            prdata[`BIT_MAIN_SRC_STATUS] <= ~onRing;
            prdata[`BIT_MAIN_SRC_SELECT] <= mainSourceSelect_q;
          end
          `OFS_OSC_STAB_STAT: prdata[`BIT_STAB_DONE] <= stabSync_q[1];
          `OFS_OSC_STAB_SEL: prdata[`STAB_SEL_W-1:0] <= stabSel_q;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// file: verif/clk_src_sel_sva.sv
// Port-level assertions for the CPU clock source selector
`timescale 1ns/1ps
module clk_src_sel_sva (
  // System
  input wire clk_sys,
  input wire nrst,
  // APB
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Clock control
  input wire ringStopAllowed,
  input wire xtalEnable,
  input wire ringEnable,
  input wire cpuClkOut,
  input wire [2:0] activeSrc
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Ring is the CPU source right out of reset
  reset_ring_a: assert property ($rose(nrst) |-> activeSrc == 3'h1 && !xtalEnable)
    else $error("reset source wrong");
  src_onehot_a: assert property ($onehot(activeSrc))
    else $error("active source not one-hot");
  // Zero wait states, one-cycle answer
  ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing wrong");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  xtal_kept_a: assert property (activeSrc == 3'h2 |-> xtalEnable)
    else $error("crystal stopped while active");
  ring_kept_a: assert property (activeSrc == 3'h1 |-> ringEnable)
    else $error("ring stopped while active");
  ring_mask_a: assert property (!ringEnable |-> ringStopAllowed)
    else $error("ring stopped without mask");
  ring_to_sub_a: assert property (activeSrc == 3'h1 |=> activeSrc != 3'h4)
    else $error("ring went to subsystem");
  sub_to_ring_a: assert property (activeSrc == 3'h4 |=> activeSrc != 3'h1)
    else $error("subsystem went to ring");
  // CPU clock is held low across a handover
  handover_low_a: assert property ($changed(activeSrc) |-> !cpuClkOut)
    else $error("cpu clock high at handover");
  // Main scenarios reached
  cover property (activeSrc == 3'h4);
  cover property (pslverr);
  cover property (!ringEnable);
endmodule
bind clk_src_sel clk_src_sel_sva chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .ringStopAllowed(ringStopAllowed),
  .xtalEnable(xtalEnable), .ringEnable(ringEnable), .cpuClkOut(cpuClkOut),
  .activeSrc(activeSrc));

// file: verif/testbench.sv
// Register-level test sequence for the CPU clock source selector
`timescale 1ns/1ps
`include "clk_src_sel_defines.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic ringClk = 0, xtalClk = 0, subClk = 0, ringStopAllowed = 1, xtalStable = 1;
  logic stopReleaseIrq = 0, xtalEnable, ringEnable, cpuClkOut;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] activeSrc, stabTimeApplied;
  int n_fail = 0, checked = 0, cyc = 0;
  clk_src_sel DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ringClk(ringClk), .xtalClk(xtalClk), .subClk(subClk),
    .ringStopAllowed(ringStopAllowed), .xtalStable(xtalStable),
    .stopReleaseIrq(stopReleaseIrq), .xtalEnable(xtalEnable), .ringEnable(ringEnable),
    .cpuClkOut(cpuClkOut), .activeSrc(activeSrc), .stabTimeApplied(stabTimeApplied));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Slow oscillators; a disabled oscillator stands still low
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ringClk <= ringEnable && ((cyc % 6) < 3);
    xtalClk <= xtalEnable && ((cyc % 4) < 2);
    subClk <= (cyc % 10) < 5;
  end
  // One APB transfer; request held until pready is sampled
  // No cycle count assumed; only the watchdog ends a stuck wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Switch waits are bounded; a stuck switch shows up in the compare
  task automatic waitSrc(input logic [2:0] s);
    for (int i = 0; i < 300 && activeSrc !== s; i++) @(posedge clk_sys);
    `CHK("activeSrc", s, activeSrc)
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic pulseIrq();
    stopReleaseIrq <= 1; repeat (4) @(posedge clk_sys); stopReleaseIrq <= 0; settle();
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog: whole sequence needs a few hundred cycles
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1;
    `CHK("activeSrc", 3'h1, activeSrc)
    apb(0, `OFS_PROC_CLK_CTRL, 0); `CHK("pcc", 32'h0, rd)
    apb(0, 12'h020, 0); `CHK("pslverr", 1'b1, err)
    apb(1, `OFS_PROC_CLK_CTRL, 32'h10); apb(0, `OFS_PROC_CLK_CTRL, 0); `CHK("pcc", 32'h0, rd)
    $display("Test reset and refusals done");
    apb(0, `OFS_OSC_STAB_STAT, 0); `CHK("osc_stab_status_reg", 32'h1, rd)
    apb(1, `OFS_MAIN_CLK_MODE, 32'h1); waitSrc(3'h2);
    apb(0, `OFS_MAIN_CLK_MODE, 0); `CHK("mcm", 32'h3, rd)
    apb(1, `OFS_MAIN_OSC_CTRL, 32'h80); apb(1, `OFS_PROC_CLK_CTRL, 32'h80); settle();
    `CHK("xtalEnable", 1'b1, xtalEnable)
    apb(1, `OFS_MAIN_OSC_CTRL, 0); apb(1, `OFS_PROC_CLK_CTRL, 0);
    apb(1, `OFS_OSC_STAB_SEL, 32'h5); pulseIrq(); `CHK("stab", 3'h5, stabTimeApplied)
    $display("Test crystal mode done");
    apb(1, `OFS_PROC_CLK_CTRL, 32'h10); waitSrc(3'h4);
    apb(0, `OFS_PROC_CLK_CTRL, 0); `CHK("pcc", 32'h30, rd)
    apb(1, `OFS_MAIN_OSC_CTRL, 32'h80); settle(); `CHK("xtalEnable", 1'b1, xtalEnable)
    apb(1, `OFS_PROC_CLK_CTRL, 32'h90); settle(); `CHK("xtalEnable", 1'b0, xtalEnable)
    apb(1, `OFS_RING_OSC_MODE, 32'h1); settle(); `CHK("ringEnable", 1'b0, ringEnable)
    apb(1, `OFS_RING_OSC_MODE, 0); apb(1, `OFS_PROC_CLK_CTRL, 32'h10);
    apb(1, `OFS_MAIN_OSC_CTRL, 0); settle();
    apb(1, `OFS_MAIN_CLK_MODE, 0); apb(0, `OFS_MAIN_CLK_MODE, 0); `CHK("mcm", 32'h3, rd)
    $display("Test subsystem mode done");
    apb(1, `OFS_PROC_CLK_CTRL, 0); waitSrc(3'h2);
    apb(0, `OFS_PROC_CLK_CTRL, 0); `CHK("pcc", 32'h0, rd)
    apb(1, `OFS_RING_OSC_MODE, 0);
    apb(1, `OFS_MAIN_CLK_MODE, 0); waitSrc(3'h1);
    apb(0, `OFS_MAIN_CLK_MODE, 0); `CHK("mcm", 32'h0, rd)
    apb(1, `OFS_PROC_CLK_CTRL, 32'h80); settle(); `CHK("xtalEnable", 1'b1, xtalEnable)
    apb(1, `OFS_MAIN_OSC_CTRL, 32'h80); settle(); `CHK("xtalEnable", 1'b0, xtalEnable)
    apb(1, `OFS_OSC_STAB_SEL, 32'h2); pulseIrq(); `CHK("stab", 3'h5, stabTimeApplied)
    $display("Test ring mode done");
    // Second reset with the strap forbidding software ring stop
    ringStopAllowed <= 0; nrst <= 0; repeat (6) @(posedge clk_sys); nrst <= 1;
    apb(0, `OFS_MAIN_OSC_CTRL, 0); `CHK("moc", 32'h0, rd)
    `CHK("activeSrc", 3'h1, activeSrc)
    apb(1, `OFS_MAIN_CLK_MODE, 32'h1); waitSrc(3'h2);
    apb(1, `OFS_RING_OSC_MODE, 32'h1); settle(); `CHK("ringEnable", 1'b1, ringEnable)
    $display("Test mask option done");
    complete_run();
  end
endmodule
